// ---- hdl/rsm_pkg.sv ----
// Purpose: constants and types for the relay switching mode control block
// Assumes: 100 MHz clock, two card slots
package rsm_pkg;
    localparam int RSM_CHANS      = 40;
    localparam int RSM_CHAN_W     = 6;
    localparam int RSM_TYPE_W     = 4;
    localparam int RSM_CLK_NS     = 10;
    localparam int RSM_SETTLE_NS  = 2000000;
    // least time, so round up
    localparam int RSM_SETTLE_CYC = (RSM_SETTLE_NS + RSM_CLK_NS - 1) / RSM_CLK_NS;

    localparam logic       RSM_ORDERED_RST = 1'b1;
    localparam logic       RSM_SINGLE_RST  = 1'b0;
    localparam logic       RSM_PAIR_RST    = 1'b0;
    localparam logic [1:0] RSM_INIT_WAIT   = 2'h3;

    typedef enum logic [3:0] {
        RSM_SET_ORDERED = 4'h0,
        RSM_SET_SINGLE  = 4'h1,
        RSM_SET_PAIR    = 4'h2,
        RSM_QRY_ORDERED = 4'h3,
        RSM_QRY_SINGLE  = 4'h4,
        RSM_QRY_PAIR    = 4'h5,
        RSM_CMD_RESET   = 4'h6,
        RSM_SYS_PRESET  = 4'h7,
        RSM_CLOSE_CH    = 4'h8,
        RSM_OPEN_CH     = 4'h9,
        RSM_OPEN_ALL    = 4'ha
    } rsm_cmd_t;

    typedef enum logic [1:0] {
        RSM_T_INIT = 2'b00,
        RSM_T_IDLE = 2'b01,
        RSM_T_BUSY = 2'b11
    } rsm_top_state_t;

    typedef enum logic {
        RSM_S_IDLE  = 1'b0,
        RSM_S_BREAK = 1'b1
    } rsm_seq_state_t;
endpackage

// ---- hdl/rsm_seq_if.sv ----
// Purpose: carries a relay target from the command logic to the sequencer
// Assumes: start is a one-cycle pulse, only given while busy is low
// Notes:   drive is the registered relay state
interface rsm_seq_if #(parameter int W = 80);
    logic         start;
    logic [W-1:0] target;
    logic         ordered;
    logic         busy;
    logic [W-1:0] drive;
    modport ctl (output start, output target, output ordered, input busy, input drive);
    modport seq (input start, input target, input ordered, output busy, output drive);
endinterface

// ---- hdl/rsm_seq.sv ----
// Purpose: applies a relay target, opening before closing when ordered
// Assumes: start only while not busy
// Notes:   settle wait covers relay release time
module rsm_seq
    import rsm_pkg::*;
#(
    parameter int W             = 2 * RSM_CHANS,
    parameter int SETTLE_CYCLES = RSM_SETTLE_CYC
) (
    input wire logic clock,
    input wire logic resetn,
    rsm_seq_if.seq   sq
);
    localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);

    rsm_seq_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [W-1:0]     pend;
    logic [W-1:0]     drive;

    assign sq.drive = drive;
    assign sq.busy  = (state == RSM_S_BREAK);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= RSM_S_IDLE;
            cnt   <= '0;
            pend  <= '0;
            drive <= '0;
        end else begin
            unique case (state)
                RSM_S_IDLE: begin
                    if (sq.start) begin
                        pend <= sq.target;
                        // only worth waiting when something opens and something closes
                        if (sq.ordered && |(drive & ~sq.target) && |(sq.target & ~drive)) begin
                            drive <= drive & sq.target;
                            cnt   <= CNT_W'(SETTLE_CYCLES - 1);
                            state <= RSM_S_BREAK;
                        end else begin
                            drive <= sq.target;
                        end
                    end
                end
                RSM_S_BREAK: begin
                    if (cnt == '0) begin
                        drive <= pend;
                        state <= RSM_S_IDLE;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
            endcase
        end
    end
endmodule

// ---- hdl/rsm_top.sv ----
// Purpose: holds switching mode settings and turns channel commands into relay drive
// Assumes: commands come from logic on the same clock; setup straps are pins
// Notes:   one command at a time, handshake by cmd_valid and cmd_ready
module rsm_top
    import rsm_pkg::*;
#(
    parameter int CHANS         = RSM_CHANS,
    parameter int CHAN_W        = RSM_CHAN_W,
    parameter int TYPE_W        = RSM_TYPE_W,
    parameter int SETTLE_CYCLES = RSM_SETTLE_CYC
) (
    input  wire logic                 clock,
    input  wire logic                 resetn,
    input  wire logic                 cmd_valid,
    input  wire logic [3:0]           cmd_code,
    input  wire logic                 cmd_value,
    input  wire logic                 cmd_slot,
    input  wire logic [CHAN_W-1:0]    cmd_chan,
    input  wire logic                 poweron_ordered,
    input  wire logic                 poweron_single,
    input  wire logic                 poweron_pair,
    input  wire logic [TYPE_W-1:0]    slot0_type,
    input  wire logic [TYPE_W-1:0]    slot1_type,
    input  wire logic                 scan_restricted,
    input  wire logic                 pattern_restricted,
    output logic                      cmd_ready,
    output logic                      resp_valid,
    output logic                      resp_data,
    output logic                      resp_error,
    output logic                      clear_scan_list,
    output logic                      clear_pattern,
    output logic                      ordered_switch_enable,
    output logic                      single_closure_mode,
    output logic                      paired_slot_mode,
    output logic [2*CHANS-1:0]        relay_drive
);
    localparam int W = 2 * CHANS;

    rsm_seq_if #(.W(W)) sq ();

    rsm_seq #(.W(W), .SETTLE_CYCLES(SETTLE_CYCLES)) u_seq (
        .clock  (clock),
        .resetn (resetn),
        .sq     (sq.seq)
    );

    // one bit per slot/channel; mirror bit added in paired slot mode
    function automatic logic [W-1:0] chan_mask(input logic slot, input logic [CHAN_W-1:0] ch,
                                               input logic pair);
        logic [W-1:0] m;
        m = '0;
        m[(slot ? CHANS : 0) + int'(ch)] = 1'b1;
        if (pair) begin
            m[(slot ? 0 : CHANS) + int'(ch)] = 1'b1;
        end
        return m;
    endfunction

    rsm_top_state_t state;
    logic [2:0]     strap_meta;
    logic [2:0]     strap;
    logic [1:0]     init_cnt;
    logic           take;
    logic           chan_ok;
    rsm_cmd_t       code;
    logic [W-1:0]   mask;
    logic           start;
    logic [W-1:0]   target;

    assign take    = cmd_valid && cmd_ready;
    assign code    = rsm_cmd_t'(cmd_code);
    assign chan_ok = int'(cmd_chan) < CHANS;
    assign mask    = chan_ok ? chan_mask(cmd_slot, cmd_chan, paired_slot_mode) : '0;
    assign relay_drive = sq.drive;
    assign sq.start    = start;
    assign sq.target   = target;
    assign sq.ordered  = ordered_switch_enable;

    // straps are pins, so synchronise before use
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            strap_meta <= '0;
            strap      <= '0;
        end else begin
            strap_meta <= {poweron_pair, poweron_single, poweron_ordered};
            strap      <= strap_meta;
        end
    end

    // command flow and handshake
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state     <= RSM_T_INIT;
            init_cnt  <= '0;
            cmd_ready <= 1'b0;
        end else begin
            unique case (state)
                RSM_T_INIT: begin
                    init_cnt <= init_cnt + 1'b1;
                    if (init_cnt == RSM_INIT_WAIT) begin
                        state     <= RSM_T_IDLE;
                        cmd_ready <= 1'b1;
                    end
                end
                RSM_T_IDLE: begin
                    if (take) begin
                        state     <= RSM_T_BUSY;
                        cmd_ready <= 1'b0;
                    end
                end
                RSM_T_BUSY: begin
                    // new commands wait until the sequencer has left its break wait, if it entered one
                    if (!sq.busy) begin
                        state     <= RSM_T_IDLE;
                        cmd_ready <= 1'b1;
                    end
                end
            endcase
        end
    end

    // mode settings
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ordered_switch_enable <= RSM_ORDERED_RST;
            single_closure_mode   <= RSM_SINGLE_RST;
            paired_slot_mode      <= RSM_PAIR_RST;
        end else if (state == RSM_T_INIT && init_cnt == RSM_INIT_WAIT) begin
            ordered_switch_enable <= strap[0];
            single_closure_mode   <= strap[1];
            paired_slot_mode      <= strap[2];
        end else if (take) begin
            unique case (code)
                RSM_SET_ORDERED: ordered_switch_enable <= cmd_value;
                RSM_SET_SINGLE:  single_closure_mode   <= cmd_value;
                RSM_SET_PAIR: begin
                    if (!cmd_value || slot0_type == slot1_type) begin
                        paired_slot_mode <= cmd_value;
                    end
                end
                RSM_CMD_RESET, RSM_SYS_PRESET: begin
                    ordered_switch_enable <= RSM_ORDERED_RST;
                    single_closure_mode   <= RSM_SINGLE_RST;
                    paired_slot_mode      <= RSM_PAIR_RST;
                end
                default: ;
            endcase
        end
    end

    // answers and list clearing pulses
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            resp_valid      <= 1'b0;
            resp_data       <= 1'b0;
            resp_error      <= 1'b0;
            clear_scan_list <= 1'b0;
            clear_pattern   <= 1'b0;
        end else begin
            resp_valid      <= 1'b0;
            resp_error      <= 1'b0;
            clear_scan_list <= 1'b0;
            clear_pattern   <= 1'b0;
            if (take) begin
                unique case (code)
                    RSM_QRY_ORDERED: begin
                        resp_valid <= 1'b1;
                        resp_data  <= ordered_switch_enable;
                    end
                    RSM_QRY_SINGLE: begin
                        resp_valid <= 1'b1;
                        resp_data  <= single_closure_mode;
                    end
                    RSM_QRY_PAIR: begin
                        resp_valid <= 1'b1;
                        resp_data  <= paired_slot_mode;
                    end
                    RSM_SET_PAIR: begin
                        if (cmd_value && slot0_type != slot1_type) begin
                            resp_error <= 1'b1;
                        end else if (cmd_value && !paired_slot_mode) begin
                            clear_scan_list <= scan_restricted;
                            clear_pattern   <= pattern_restricted;
                        end
                    end
                    RSM_CLOSE_CH, RSM_OPEN_CH: begin
                        resp_error <= !chan_ok;
                    end
                    default: ;
                endcase
            end
        end
    end

    // relay target for the sequencer
    always_comb begin
        start  = 1'b0;
        target = sq.drive;
        if (take) begin
            unique case (code)
                RSM_CLOSE_CH: begin
                    start = chan_ok;
                    // single closure drops whatever was closed before
                    target = (single_closure_mode ? '0 : sq.drive) | mask;
                end
                RSM_OPEN_CH: begin
                    start  = chan_ok;
                    target = sq.drive & ~mask;
                end
                RSM_OPEN_ALL: begin
                    start  = 1'b1;
                    target = '0;
                end
                RSM_SET_SINGLE: begin
                    start  = cmd_value && !single_closure_mode;
                    target = start ? '0 : sq.drive;
                end
                default: ;
            endcase
        end
    end
endmodule

// ---- verif/rsm_relay_model.sv ----
// Purpose: relay contacts on the cards, driven by relay_drive
// Assumes: contact makes at once, breaks RELEASE cycles after drive drops
// Notes:   slow release is what makes ordered switching matter
module rsm_relay_model #(
    parameter int W       = 80,
    parameter int RELEASE = 3
) (
    input  wire logic         clock,
    input  wire logic         resetn,
    input  wire logic [W-1:0] drive,
    output logic      [W-1:0] contact
);
    timeunit 1ns;
    timeprecision 1ps;
    int hold [W];
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            contact <= '0;
            hold <= '{default: 0};
        end else begin
            for (int i = 0; i < W; i++) begin
                if (drive[i]) begin
                    contact[i] <= 1'h1;
                    hold[i] <= RELEASE;
                end else if (hold[i] > 0) begin
                    hold[i] <= hold[i] - 1;
                end else begin
                    contact[i] <= 1'h0;
                end
            end
        end
    end
endmodule

// ---- verif/rsm_top_properties.sv ----
// Purpose: port checks of rsm_top
// Assumes: one clock, async active low reset
// Notes:   bound to every rsm_top
module rsm_top_properties
    import rsm_pkg::*;
#(
    parameter int CHANS = RSM_CHANS
) (
    input wire logic               clock,
    input wire logic               resetn,
    input wire logic               cmd_valid,
    input wire logic [3:0]         cmd_code,
    input wire logic               cmd_value,
    input wire logic [3:0]         slot0_type,
    input wire logic [3:0]         slot1_type,
    input wire logic               cmd_ready,
    input wire logic               resp_valid,
    input wire logic               resp_data,
    input wire logic               resp_error,
    input wire logic               ordered_switch_enable,
    input wire logic               single_closure_mode,
    input wire logic               paired_slot_mode,
    input wire logic [2*CHANS-1:0] relay_drive
);
    timeunit 1ns;
    timeprecision 1ps;
    logic take;
    assign take = cmd_valid && cmd_ready;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    a_ordered_query: assert property (
        take && cmd_code == 4'h3 |=> resp_valid && resp_data == ordered_switch_enable)
        else $error("bad ordered query");
    a_single_query: assert property (
        take && cmd_code == 4'h4 |=> resp_valid && resp_data == single_closure_mode)
        else $error("bad single query");
    a_pair_query: assert property (
        take && cmd_code == 4'h5 |=> resp_valid && resp_data == paired_slot_mode)
        else $error("bad pair query");
    a_set_ordered: assert property (
        take && cmd_code == 4'h0 |=> ordered_switch_enable == $past(cmd_value))
        else $error("ordered not set");
    a_set_single: assert property (
        take && cmd_code == 4'h1 |=> single_closure_mode == $past(cmd_value))
        else $error("single not set");
    a_reset_defaults: assert property (
        take && (cmd_code == 4'h6 || cmd_code == 4'h7)
        |=> ordered_switch_enable && !single_closure_mode && !paired_slot_mode)
        else $error("bad defaults");
    a_single_lone: assert property (
        take && cmd_code == 4'h8 && single_closure_mode && !paired_slot_mode
        |=> ($countones(relay_drive) <= 1) [*8])
        else $error("two relays closed");
    a_break_first: assert property (
        ordered_switch_enable |-> !(|(relay_drive & ~$past(relay_drive))
        && |(~relay_drive & $past(relay_drive))))
        else $error("open and close together");
    a_pair_refused: assert property (
        take && cmd_code == 4'h2 && cmd_value && slot0_type != slot1_type
        |=> resp_error && paired_slot_mode == $past(paired_slot_mode))
        else $error("pair not refused");
    a_opens_all: assert property (
        take && cmd_code == 4'h1 && cmd_value && !single_closure_mode
        |-> ##[1:3] relay_drive == '0)
        else $error("relays not opened");
endmodule
bind rsm_top rsm_top_properties #(.CHANS(CHANS)) i_rsm_top_properties (.clock, .resetn,
    .cmd_valid, .cmd_code, .cmd_value, .slot0_type, .slot1_type, .cmd_ready, .resp_valid,
    .resp_data, .resp_error, .ordered_switch_enable, .single_closure_mode,
    .paired_slot_mode, .relay_drive);

// ---- verif/rsm_top_tb.sv ----
// Purpose: self-checking bench of rsm_top
// Assumes: settle cut to 4 cycles, contacts release in 3
// Notes:   answers queued by the driver, checked by a monitor
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module rsm_top_tb;
    import rsm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SC = 4;
    logic clock = 0, resetn = 0, cmd_valid = 0, cmd_value = 0, cmd_slot = 0;
    logic [3:0] cmd_code = '0, slot0_type = 4'h3, slot1_type = 4'h3;
    logic [5:0] cmd_chan = '0;
    logic poweron_ordered = 0, poweron_single = 1, poweron_pair = 1;
    logic scan_restricted = 0, pattern_restricted = 0;
    logic cmd_ready, resp_valid, resp_data, resp_error, clear_scan_list, clear_pattern;
    logic ordered_switch_enable, single_closure_mode, paired_slot_mode;
    logic [2:0] modes, exp_r, expq[$];
    logic [79:0] relay_drive, contact, exp_rd;
    logic [15:0] rnd = 16'h6d43;
    int fails = 0, cmp_count = 0, cycles = 0, peak = 0, clr_n = 0, clr_p = 0, a, b;
    assign modes = {ordered_switch_enable, single_closure_mode, paired_slot_mode};
    always #5 clock = ~clock;
    rsm_top #(.SETTLE_CYCLES(SC)) i_rsm_top (.clock, .resetn, .cmd_valid, .cmd_code,
        .cmd_value, .cmd_slot, .cmd_chan, .poweron_ordered, .poweron_single, .poweron_pair,
        .slot0_type, .slot1_type, .scan_restricted, .pattern_restricted, .cmd_ready,
        .resp_valid, .resp_data, .resp_error, .clear_scan_list, .clear_pattern,
        .ordered_switch_enable, .single_closure_mode, .paired_slot_mode, .relay_drive);
    rsm_relay_model #(.W(80), .RELEASE(3)) i_rsm_relay_model (.clock, .resetn,
        .drive(relay_drive), .contact);
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // sc is {slot, channel}
    task automatic cmd(input logic [3:0] c, input logic v, input logic [6:0] sc);
        int n;
        n = 0;
        @(negedge clock);
        cmd_valid = 1'h1;
        cmd_code = c;
        cmd_value = v;
        {cmd_slot, cmd_chan} = sc;
        // ready seen at a falling edge is what the next rising edge takes
        while (cmd_ready !== 1'h1 && n < 50) begin
            @(negedge clock);
            n++;
        end
        @(negedge clock);
        cmd_valid = 1'h0;
        while (cmd_ready !== 1'h1 && n < 100) begin
            @(negedge clock);
            n++;
        end
    endtask
    task automatic ask(input logic [3:0] c, input logic e);
        expq.push_back({2'h1, e});
        cmd(c, 1'h0, 7'h0);
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(negedge clock) begin
        if (clear_scan_list === 1'h1) clr_n++;
        if (clear_pattern === 1'h1) clr_p++;
        if (resp_valid === 1'h1 || resp_error === 1'h1) begin
            exp_r = expq.pop_front();
            `CHK({resp_error, resp_valid, resp_valid & resp_data}, exp_r)
        end
    end
    // follow contacts as they settle, not at the edge that moves them
    always @(contact) begin
        if ($countones(contact) > peak) peak = $countones(contact);
    end
    // whole run needs well under 1000 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            end_sim();
        end
    end
    initial begin
        repeat (3) @(negedge clock);
        resetn = 1'h1;
        repeat (6) @(negedge clock);
        `CHK(modes, 3'h3)
        cmd(RSM_CMD_RESET, 1'h0, 7'h0);
        `CHK(modes, 3'h4)
        $display("defaults done");
        for (int v = 0; v < 2; v++) begin
            for (int k = 0; k < 3; k++) begin
                cmd(4'(k), 1'(v), 7'h0);
                ask(4'(k + 3), 1'(v));
            end
        end
        cmd(RSM_SYS_PRESET, 1'h0, 7'h0);
        `CHK(modes, 3'h4)
        $display("settings done");
        slot1_type = 4'h5;
        expq.push_back(3'h4);
        cmd(RSM_SET_PAIR, 1'h1, 7'h0);
        slot1_type = 4'h3;
        scan_restricted = 1'h1;
        cmd(RSM_SET_PAIR, 1'h1, 7'h0);
        `CHK(modes, 3'h5)
        `CHK(clr_n, 1)
        `CHK(clr_p, 0)
        cmd(RSM_SET_ORDERED, 1'h0, 7'h0);
        rnd = lfsr(rnd);
        a = rnd % 40;
        b = (a + 7) % 40;
        cmd(RSM_CLOSE_CH, 1'h0, 7'(a));
        exp_rd = '0;
        exp_rd[a] = 1'h1;
        exp_rd[a + 40] = 1'h1;
        `CHK(relay_drive, exp_rd)
        cmd(RSM_OPEN_CH, 1'h0, 7'(a + 64));
        `CHK(relay_drive, 80'h0)
        cmd(RSM_SET_PAIR, 1'h0, 7'h0);
        scan_restricted = 1'h0;
        pattern_restricted = 1'h1;
        cmd(RSM_SET_PAIR, 1'h1, 7'h0);
        `CHK(clr_n, 1)
        `CHK(clr_p, 1)
        cmd(RSM_SET_PAIR, 1'h0, 7'h0);
        $display("pairing done");
        cmd(RSM_CLOSE_CH, 1'h0, 7'(a));
        cmd(RSM_CLOSE_CH, 1'h0, 7'(b));
        `CHK(relay_drive, (80'h1 << a) | (80'h1 << b))
        cmd(RSM_SET_SINGLE, 1'h1, 7'h0);
        `CHK(relay_drive, 80'h0)
        cmd(RSM_CLOSE_CH, 1'h0, 7'(a));
        peak = 0;
        cmd(RSM_CLOSE_CH, 1'h0, 7'(b));
        `CHK(relay_drive, 80'h1 << b)
        `CHK(peak, 2)
        cmd(RSM_SET_ORDERED, 1'h1, 7'h0);
        peak = 0;
        cmd(RSM_CLOSE_CH, 1'h0, 7'(a));
        `CHK(relay_drive, 80'h1 << a)
        `CHK(peak, 1)
        expq.push_back(3'h4);
        cmd(RSM_CLOSE_CH, 1'h0, 7'd45);
        `CHK(relay_drive, 80'h1 << a)
        cmd(RSM_OPEN_ALL, 1'h0, 7'h0);
        `CHK(relay_drive, 80'h0)
        `CHK(expq.size(), 0)
        $display("switching done");
        end_sim();
    end
endmodule
